//--- pulse_pattern_trigger_select.sv
/*
  Top of the trigger selection block: APB register file, two generator
  instances of four groups each, registered update strobes.
  Assumes timer compare strobes are one-cycle pulses on clk.
*/
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module pulse_pattern_trigger_select
  import ppg_trig_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  motor_timer_unit_cmp_a,
  input  wire logic [3:0]  motor_timer_unit_cmp_b,
  input  wire logic [3:0]  general_timer_unit_cmp_a,
  input  wire logic [3:0]  general_timer_unit_cmp_b,
  output logic      [3:0]  pattern_generator_first_update,
  output logic      [3:0]  pattern_generator_second_update
);
  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic       rst_meta_q;
  logic       rst_n_q;
  logic [7:0] trigger_unit_select_q;
  logic [7:0] first_ctl_q;
  logic [7:0] first_mod_q;
  logic [7:0] second_ctl_q;
  logic [7:0] second_mod_q;
  logic [7:0] status_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] first_upd;
  logic [3:0] second_upd;
  logic [3:0] first_upd_q;
  logic [3:0] second_upd_q;
  logic [3:0] second_a;
  logic [3:0] second_b;
  logic       sel;
  logic       access;
  logic       wr_en;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_UNIT_SEL) || (a == OFF_FIRST_CTL) || (a == OFF_FIRST_MOD) ||
             (a == OFF_SECND_CTL) || (a == OFF_SECND_MOD) || (a == OFF_STATUS);
  endfunction

  // One wait state: pready rises in the second access cycle.
  assign access = psel & penable & ~pready_q;
  assign wr_en  = psel & penable & pready_q & pwrite & mapped(paddr);

  // Handshake, error and read data are all registered.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped(paddr);
      prdata_q  <= 32'h0000_0000;
      if (access && !pwrite)
      begin
        unique case (paddr)
          OFF_UNIT_SEL:  prdata_q[7:0] <= trigger_unit_select_q;
          OFF_FIRST_CTL: prdata_q[7:0] <= first_ctl_q;
          OFF_FIRST_MOD: prdata_q[7:0] <= first_mod_q;
          OFF_SECND_CTL: prdata_q[7:0] <= second_ctl_q;
          OFF_SECND_MOD: prdata_q[7:0] <= second_mod_q;
          OFF_STATUS:    prdata_q[7:0] <= status_q;
          default:       prdata_q      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable registers; control bytes are stored whole, of the select and mode words only the select bit and mode nibbles.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      trigger_unit_select_q <= RST_UNIT_SEL;
      first_ctl_q           <= RST_CTL;
      first_mod_q           <= RST_MOD;
      second_ctl_q          <= RST_CTL;
      second_mod_q          <= RST_MOD;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        OFF_UNIT_SEL:  trigger_unit_select_q <= {7'h00, pwdata[SEL_BIT]};
        OFF_FIRST_CTL: first_ctl_q           <= pwdata[7:0];
        OFF_FIRST_MOD: first_mod_q           <= {4'h0, pwdata[3:0]};
        OFF_SECND_CTL: second_ctl_q          <= pwdata[7:0];
        OFF_SECND_MOD: second_mod_q          <= {4'h0, pwdata[3:0]};
        default:       first_ctl_q           <= first_ctl_q;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Trigger source selection
  // ------------------------------------------------------------------
  assign sel = trigger_unit_select_q[SEL_BIT];
  assign second_a = sel ? general_timer_unit_cmp_a : motor_timer_unit_cmp_a;
  assign second_b = sel ? general_timer_unit_cmp_b : motor_timer_unit_cmp_b;

  // One picker per group, each with its own field and mode bit.
  // independent groups
  for (genvar g = 0; g < GROUPS; g++)
  begin : g_grp
    trigger_group u_first (
      .compare_source  (first_ctl_q[SRC_W*g +: SRC_W]),
      .nonoverlap_mode (first_mod_q[g]),
      .cmp_a           (motor_timer_unit_cmp_a),
      .cmp_b           (motor_timer_unit_cmp_b),
      .update          (first_upd[g])
    );
    trigger_group u_second (
      .compare_source  (second_ctl_q[SRC_W*g +: SRC_W]),
      .nonoverlap_mode (second_mod_q[g]),
      .cmp_a           (second_a),
      .cmp_b           (second_b),
      .update          (second_upd[g])
    );
  end

  // Update strobes are registered; status keeps the last nonzero pair.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      first_upd_q  <= 4'h0;
      second_upd_q <= 4'h0;
      status_q     <= 8'h00;
    end
    else
    begin
      first_upd_q  <= first_upd;
      second_upd_q <= second_upd;
      if (|{second_upd, first_upd})
      begin
        status_q <= {second_upd, first_upd};
      end
    end
  end

  assign prdata                          = prdata_q;
  assign pready                          = pready_q;
  assign pslverr                         = pslverr_q;
  assign pattern_generator_first_update  = first_upd_q;
  assign pattern_generator_second_update = second_upd_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  property p_unit_sel;
    sel && motor_timer_unit_cmp_a != 4'h0 && general_timer_unit_cmp_a == 4'h0 &&
    general_timer_unit_cmp_b == 4'h0 |=> second_upd_q == 4'h0;
  endproperty
  a_unit_sel: assert property (p_unit_sel) else $error("second used motor unit");

  property p_first_map;
    motor_timer_unit_cmp_a[first_ctl_q[1:0]] |=> first_upd_q[0];
  endproperty
  a_first_map: assert property (p_first_map) else $error("first map wrong");

  property p_second_motor;
    !sel && motor_timer_unit_cmp_a[second_ctl_q[1:0]] |=> second_upd_q[0];
  endproperty
  a_second_motor: assert property (p_second_motor) else $error("motor map wrong");

  property p_second_gen;
    sel && general_timer_unit_cmp_a[second_ctl_q[1:0]] |=> second_upd_q[0];
  endproperty
  a_second_gen: assert property (p_second_gen) else $error("general map wrong");

  property p_normal;
    !first_mod_q[1] && motor_timer_unit_cmp_a == 4'h0 |=> !first_upd_q[1];
  endproperty
  a_normal: assert property (p_normal) else $error("normal updated on B");

  property p_nonoverlap;
    first_mod_q[2] && motor_timer_unit_cmp_b[first_ctl_q[5:4]] |=> first_upd_q[2];
  endproperty
  a_nonoverlap: assert property (p_nonoverlap) else $error("B missed");

  property p_events_follow;
    !sel && motor_timer_unit_cmp_a == 4'h0 && motor_timer_unit_cmp_b == 4'h0
    |=> second_upd_q == 4'h0;
  endproperty
  a_events_follow: assert property (p_events_follow) else $error("wrong unit event");

  property p_independent;
    first_ctl_q[1:0] != first_ctl_q[7:6] && motor_timer_unit_cmp_b == 4'h0 &&
    motor_timer_unit_cmp_a == (4'h1 << first_ctl_q[1:0])
    |=> first_upd_q[0] && !first_upd_q[3];
  endproperty
  a_independent: assert property (p_independent) else $error("groups not independent");

  c_first: cover property (first_upd_q != 4'h0);
  c_second_gen: cover property (sel && second_upd_q != 4'h0);
  c_on_b: cover property (first_mod_q[0] && motor_timer_unit_cmp_b != 4'h0 ##1 first_upd_q[0]);
endmodule

//--- trigger_group.sv
/*
  Holds the shared constants package and the per-group trigger picker.
  Assumes compare strobes come from timer logic on the same clock.
*/
// What this block does
// - Select bit picks second instance's timer unit
// - First instance codes map motor channels 0-3
// - Second, select 0: codes map motor channels
// - Second, select 1: codes map general channels
// - Mode 0 updates on compare A only
// - Mode 1 updates on compare A or B
// - Second instance events follow selected unit
package ppg_trig_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_UNIT_SEL  = 8'h00;
  localparam logic [7:0] OFF_FIRST_CTL = 8'h04;
  localparam logic [7:0] OFF_FIRST_MOD = 8'h08;
  localparam logic [7:0] OFF_SECND_CTL = 8'h0c;
  localparam logic [7:0] OFF_SECND_MOD = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  // ------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------
  localparam int         GROUPS        = 4;
  localparam int         SRC_W         = 2;
  localparam int         SEL_BIT       = 0;
  localparam logic [7:0] RST_UNIT_SEL  = 8'h00;
  localparam logic [7:0] RST_CTL       = 8'h00;
  localparam logic [7:0] RST_MOD       = 8'h00;
endpackage

`timescale 1ns/1ps

module trigger_group
  import ppg_trig_pkg::*;
(
  input  wire logic [1:0] compare_source,
  input  wire logic       nonoverlap_mode,
  input  wire logic [3:0] cmp_a,
  input  wire logic [3:0] cmp_b,
  output logic            update
);
  // ------------------------------------------------------------------
  // Update event picker
  // ------------------------------------------------------------------
  // Code selects channel; mode adds compare B as an extra update event.
  // mode gates B
  assign update = cmp_a[compare_source] | (nonoverlap_mode & cmp_b[compare_source]);
endmodule

//--- timer_units_model.sv
/*
  Model of the two timer units: one-cycle compare strobes on request.
  Assumes the bench asks for events on clk and waits for them.
*/
`timescale 1ns/1ps

module timer_units_model
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        go,
  input  wire logic [3:0]  delay,
  input  wire logic [15:0] mask,
  output logic      [15:0] strobe
);
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic [15:0] mask_q;

  // Waits the asked delay, then pulses the chosen strobes for one cycle.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      mask_q <= 16'h0000;
      strobe <= 16'h0000;
    end
    else if (go)
    begin
      cnt_q  <= delay;
      busy_q <= 1'b1;
      mask_q <= mask;
      strobe <= 16'h0000;
    end
    else
    begin
      strobe <= (busy_q && cnt_q == 4'h0) ? mask_q : 16'h0000;
      busy_q <= busy_q && cnt_q != 4'h0;
      cnt_q  <= cnt_q - 4'h1;
    end
  end
endmodule

//--- pulse_pattern_trigger_select_tb_top.sv
/*
  Self-checking bench for the trigger selection block.
  Assumes the timer model file is compiled first.
*/
`timescale 1ns/1ps

module pulse_pattern_trigger_select_tb_top
  import ppg_trig_pkg::*;
;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, sel;
  logic [3:0]  delay = 4'h0, first_upd, second_upd, m1, m2;
  logic [15:0] mask = 16'h0, stb;
  logic [7:0]  c1, c2, st_exp = 8'h00;
  int          n_mismatch = 0, compares = 0, cyc = 0;

  pulse_pattern_trigger_select dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_timer_unit_cmp_a(stb[3:0]), .motor_timer_unit_cmp_b(stb[7:4]),
    .general_timer_unit_cmp_a(stb[11:8]), .general_timer_unit_cmp_b(stb[15:12]),
    .pattern_generator_first_update(first_upd),
    .pattern_generator_second_update(second_upd));
  timer_units_model tmr (.clk(clk), .reset_n(reset_n), .go(go), .delay(delay),
    .mask(mask), .strobe(stb));

  // Clock and a cycle ceiling that cuts a hang short.
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready and takes the answer at that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected group strobes for one instance from its fields.
  function automatic logic [3:0] pick(logic [7:0] c, logic [3:0] m, logic [3:0] a,
                                      logic [3:0] b);
    for (int g = 0; g < 4; g++)
      pick[g] = a[c[2*g+:2]] | (m[g] & b[c[2*g+:2]]);
  endfunction

  // Asks the timers for strobes, then checks both instances a cycle later.
  task automatic fire(input logic [15:0] m, input logic [3:0] dl);
    int n;
    logic [3:0] e1, e2;
    @(posedge clk);
    go    <= 1'b1;
    mask  <= m;
    delay <= dl;
    @(posedge clk);
    go    <= 1'b0;
    n = 0;
    while (stb === 16'h0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    e1 = pick(c1, m1, m[3:0], m[7:4]);
    e2 = sel ? pick(c2, m2, m[11:8], m[15:12]) : pick(c2, m2, m[3:0], m[7:4]);
    chk("first", first_upd, e1);
    chk("second", second_upd, e2);
    if ({e2, e1} != 8'h00)
      st_exp = {e2, e1};
    // Strobes last one cycle, so both outputs are quiet again.
    @(posedge clk);
    chk("first idle", first_upd, 4'h0);
    chk("second idle", second_upd, 4'h0);
  endtask

  task automatic t_regs();
    logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      chk("reset", rd, 32'h0);
    end
    apb(1'b1, OFF_FIRST_MOD, 32'hff);
    apb(1'b0, OFF_FIRST_MOD, 32'h0);
    chk("mode", rd, 32'h0f);
    chk("mapped err", {31'h0, er}, 32'h0);
    apb(1'b1, 8'h18, 32'h5a);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped rd err", {31'h0, er}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_units(input logic s);
    sel = s;
    apb(1'b1, OFF_UNIT_SEL, {31'h0, s});
    for (int k = 0; k < 4; k++)
    begin
      fire({12'h0, 4'h1 << k}, 4'h0);
      fire({8'h0, 4'h1 << k, 4'h0}, 4'h0);
      fire({4'h0, 4'h1 << k, 8'h0}, 4'h3);
      fire({4'h1 << k, 12'h0}, 4'h1);
    end
    $display("test units %0d done", s);
  endtask

  initial
  begin
    c1 = 8'h1b;
    m1 = 4'h5;
    c2 = 8'he4;
    m2 = 4'ha;
    sel = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    apb(1'b1, OFF_FIRST_CTL, {24'h0, c1});
    apb(1'b1, OFF_FIRST_MOD, {28'h0, m1});
    apb(1'b1, OFF_SECND_CTL, {24'h0, c2});
    apb(1'b1, OFF_SECND_MOD, {28'h0, m2});
    t_units(1'b0);
    t_units(1'b1);
    t_units(1'b0);
    apb(1'b0, OFF_SECND_CTL, 32'h0);
    chk("second ctl", rd, {24'h0, c2});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, {24'h0, st_exp});
    $display("test readback done");
    print_verdict();
  end
endmodule
